/* File: shared/bfp_pkg.sv */
// constants and types for the buck fault-protection sequencer
`default_nettype none
package bfp_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned LS_SAMPLE_NS = 50;
  localparam int unsigned MIN_OFF_NS = 200;
  localparam int unsigned HS_BLANK_NS = 200;
  localparam int unsigned UV_FILTER_NS = 7000;
  localparam int unsigned COOL_US = 5500;
  localparam int unsigned ISS_US = 3600;
  localparam int unsigned LS_SAMPLE_CYC = (LS_SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HS_BLANK_CYC = (HS_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned UV_FILTER_CYC = (UV_FILTER_NS * CLK_MHZ) / 1000;
  localparam int unsigned COOL_CYC = COOL_US * CLK_MHZ;
  localparam int unsigned ISS_CYC = ISS_US * CLK_MHZ;
  localparam int unsigned OC_EVENT_LIMIT = 15;
  localparam int unsigned OC_CLEAR_RUN = 32;
  localparam int unsigned TMR_W = 24;
  localparam int unsigned CNT_W = 6;
  typedef enum logic [1:0] {
    BFP_RUN,
    BFP_COOL,
    BFP_ISS
  } bfp_mode_t;
  typedef enum logic [1:0] {
    BFP_PH_HIGH,
    BFP_PH_LOW,
    BFP_PH_WAIT
  } bfp_phase_t;
endpackage : bfp_pkg
`default_nettype wire

/* File: hdl/bfp_sequencer.sv */
// fault-protection sequencer for a synchronous buck controller
// Summary of operation
// RULE1: sample low-side comparator 50 ns after turn-on
// RULE2: high-side on at every cycle start normally
// RULE3: low-side drop over setpoint enters current limit
// RULE4: in current limit skip cycle-start high pulse
// RULE5: limited cycle: high on when current falls back
// RULE6: pwm comparator still ends high-side pulse
// RULE7: low-side limiting only during off-time
// RULE8: enforce 200 ns minimum off-time each cycle
// RULE9: hiccup after 15 counted over-current events
// RULE10: 32 clean cycles between events clear counter
// RULE11: blank high-side comparator 200 ns after turn-on
// RULE12: unblanked high-side trip enters hiccup immediately
// RULE13: undervoltage guard active only after soft-start
// RULE14: undervoltage over 7 us enters hiccup
// RULE15: hiccup: 5.5 ms off, then 3.6 ms soft-start
// RULE16: count over-current once per off-time start
// RULE17: during soft-start undervoltage cannot cause hiccup
// RULE18: hiccup entry clears counter and undervoltage filter
`timescale 1ns/10ps
`default_nettype none
module bfp_sequencer
  import bfp_pkg::*;
#(
  parameter int unsigned P_COOL_CYC = COOL_CYC,
  parameter int unsigned P_ISS_CYC = ISS_CYC,
  parameter int unsigned P_OC_LIMIT = OC_EVENT_LIMIT,
  parameter int unsigned P_CLEAR_RUN = OC_CLEAR_RUN
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cycle_start,
  input wire logic i_pwm_end,
  input wire logic i_ls_over_limit,
  input wire logic i_hs_over_limit,
  input wire logic i_output_undervoltage_guard,
  input wire logic i_ext_ss_done,
  output logic o_hs_gate,
  output logic o_ls_gate,
  output logic o_current_limit,
  output logic o_hiccup,
  output logic o_internal_ss,
  output logic o_hs_blank
);

  localparam logic [TMR_W-1:0] LS_SAMPLE_T = TMR_W'(LS_SAMPLE_CYC);
  localparam logic [TMR_W-1:0] MIN_OFF_T = TMR_W'(MIN_OFF_CYC);
  localparam logic [TMR_W-1:0] HS_BLANK_T = TMR_W'(HS_BLANK_CYC);
  localparam logic [TMR_W-1:0] UV_FILT_T = TMR_W'(UV_FILTER_CYC);
  localparam logic [TMR_W-1:0] COOL_T = TMR_W'(P_COOL_CYC);
  localparam logic [TMR_W-1:0] ISS_T = TMR_W'(P_ISS_CYC);
  localparam logic [CNT_W-1:0] OC_LIM = CNT_W'(P_OC_LIMIT);
  localparam logic [CNT_W-1:0] CLR_RUN = CNT_W'(P_CLEAR_RUN);
  localparam logic [TMR_W-1:0] ONE_T = TMR_W'(1);
  localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

  // mode state
  bfp_mode_t mode_ff, nxt_mode;
  logic [TMR_W-1:0] mode_tmr_ff, nxt_mode_tmr;
  // switching phase state
  bfp_phase_t ph_ff, nxt_ph;
  logic [TMR_W-1:0] ph_tmr_ff, nxt_ph_tmr;
  logic climit_ff, nxt_climit;
  logic sampled_ff, nxt_sampled;
  logic hs_gate_ff, nxt_hs_gate;
  logic ls_gate_ff, nxt_ls_gate;
  logic blank_ff, nxt_blank;
  // fault bookkeeping
  logic [CNT_W-1:0] oc_cnt_ff, nxt_oc_cnt;
  logic [CNT_W-1:0] clean_cnt_ff, nxt_clean_cnt;
  logic [TMR_W-1:0] uv_tmr_ff, nxt_uv_tmr;
  logic hiccup_ff, nxt_hiccup;
  logic iss_ff, nxt_iss;

  logic switching;
  logic off_sample;
  logic hs_trip;
  logic ls_trip;
  logic uv_trip;
  logic skip_cyc;
  logic enter_hiccup;

  assign switching = (mode_ff != BFP_COOL);

  // decisions taken from present state
  always_comb begin
    // first low-side sample, LS_SAMPLE_T clocks into the off-time
    off_sample = switching && (ph_ff == BFP_PH_LOW) && !sampled_ff &&
      (ph_tmr_ff >= LS_SAMPLE_T); // RULE1 RULE16
    // limited and still over at cycle start: pulse skipped
    skip_cyc = switching && (ph_ff == BFP_PH_LOW) && climit_ff &&
      sampled_ff && i_cycle_start && i_ls_over_limit; // RULE4
    ls_trip = 1'b0;
    if (off_sample && i_ls_over_limit && oc_cnt_ff + ONE_C >= OC_LIM) begin
      ls_trip = 1'b1; // RULE9
    end
    // unblanked short while the high side is on: no counting
    hs_trip = switching && hs_gate_ff && !blank_ff &&
      i_hs_over_limit; // RULE11 RULE12
    // only once the filter span has run out without a gap
    uv_trip = (mode_ff == BFP_RUN) && i_ext_ss_done &&
      i_output_undervoltage_guard && (uv_tmr_ff >= UV_FILT_T); // RULE14 RULE17
    enter_hiccup = ls_trip || hs_trip || uv_trip;
  end

  // mode next state
  // cool-down, then internal soft-start, both timed in clocks
  always_comb begin
    nxt_mode = mode_ff;
    nxt_mode_tmr = mode_tmr_ff;
    nxt_hiccup = 1'b0;
    nxt_iss = 1'b0;
    if (enter_hiccup) begin
      nxt_mode = BFP_COOL; // RULE15
      nxt_mode_tmr = '0;
    end else begin
      unique case (mode_ff)
        BFP_RUN: begin
          nxt_mode_tmr = '0;
        end
        BFP_COOL: begin
          if (mode_tmr_ff + ONE_T >= COOL_T) begin
            nxt_mode = BFP_ISS; // RULE15
            nxt_mode_tmr = '0;
          end else begin
            nxt_mode_tmr = mode_tmr_ff + ONE_T;
          end
        end
        BFP_ISS: begin
          if (mode_tmr_ff + ONE_T >= ISS_T) begin
            nxt_mode = BFP_RUN; // RULE15
            nxt_mode_tmr = '0;
          end else begin
            nxt_mode_tmr = mode_tmr_ff + ONE_T;
          end
        end
        // illegal code: fall back to regulation
        default: begin
          nxt_mode = BFP_RUN;
          nxt_mode_tmr = '0;
        end
      endcase
    end
    nxt_hiccup = (nxt_mode == BFP_COOL);
    nxt_iss = (nxt_mode == BFP_ISS);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mode_ff <= BFP_RUN;
      mode_tmr_ff <= '0;
      hiccup_ff <= 1'b0;
      iss_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      mode_tmr_ff <= nxt_mode_tmr;
      hiccup_ff <= nxt_hiccup;
      iss_ff <= nxt_iss;
    end
  end

  // switching phase next state
  always_comb begin
    nxt_ph = ph_ff;
    nxt_ph_tmr = ph_tmr_ff;
    nxt_climit = climit_ff;
    nxt_sampled = sampled_ff;
    nxt_hs_gate = 1'b0;
    nxt_ls_gate = 1'b0;
    nxt_blank = 1'b0;
    // hiccup or cool-down: both gates off, wait for a cycle start
    if (enter_hiccup || !switching) begin
      nxt_ph = BFP_PH_WAIT; // RULE15
      nxt_ph_tmr = '0;
      nxt_climit = 1'b0;
      nxt_sampled = 1'b0;
    end else begin
      unique case (ph_ff)
        BFP_PH_HIGH: begin
          // pulse end set by the pwm comparator
          if (i_pwm_end) begin
            nxt_ph = BFP_PH_LOW; // RULE6
            nxt_ph_tmr = '0;
            nxt_sampled = 1'b0;
          end else begin
            nxt_ph_tmr = ph_tmr_ff + ONE_T;
          end
        end
        BFP_PH_LOW: begin
          nxt_ph_tmr = ph_tmr_ff + ONE_T;
          if (off_sample) begin
            nxt_sampled = 1'b1;
            nxt_climit = i_ls_over_limit; // RULE3 RULE7
          end
          if (ph_tmr_ff + ONE_T >= MIN_OFF_T) begin // RULE8
            // back under the limit: restart the high side at once
            if (climit_ff && (sampled_ff || off_sample) &&
              !i_ls_over_limit) begin
              nxt_ph = BFP_PH_HIGH; // RULE5
              nxt_ph_tmr = '0;
              nxt_climit = 1'b0;
            end else if (i_cycle_start && !climit_ff &&
              !(off_sample && i_ls_over_limit)) begin
              nxt_ph = BFP_PH_HIGH; // RULE2
              nxt_ph_tmr = '0;
            end
          end
          // skipped cycle still counts: sample again on the next edge
          if (skip_cyc) begin
            nxt_sampled = 1'b0; // RULE4 RULE9
          end
          // cycle start while limited: pulse skipped, keep low on
        end
        BFP_PH_WAIT: begin
          nxt_ph_tmr = '0;
          if (i_cycle_start) begin
            nxt_ph = BFP_PH_HIGH; // RULE2
          end
        end
        default: begin
          nxt_ph = BFP_PH_WAIT;
          nxt_ph_tmr = '0;
        end
      endcase
    end
    nxt_hs_gate = (nxt_ph == BFP_PH_HIGH);
    nxt_ls_gate = (nxt_ph == BFP_PH_LOW);
    // first unblanked sample falls 200 ns after turn-on
    nxt_blank = (nxt_ph == BFP_PH_HIGH) &&
      (nxt_ph_tmr + ONE_T < HS_BLANK_T); // RULE11
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ph_ff <= BFP_PH_WAIT;
      ph_tmr_ff <= '0;
      climit_ff <= 1'b0;
      sampled_ff <= 1'b0;
      hs_gate_ff <= 1'b0;
      ls_gate_ff <= 1'b0;
      blank_ff <= 1'b0;
    end else begin
      ph_ff <= nxt_ph;
      ph_tmr_ff <= nxt_ph_tmr;
      climit_ff <= nxt_climit;
      sampled_ff <= nxt_sampled;
      hs_gate_ff <= nxt_hs_gate;
      ls_gate_ff <= nxt_ls_gate;
      blank_ff <= nxt_blank;
    end
  end

  // event counter, clean-run counter, undervoltage filter
  always_comb begin
    nxt_oc_cnt = oc_cnt_ff;
    nxt_clean_cnt = clean_cnt_ff;
    nxt_uv_tmr = '0;
    // hiccup entry wins over any count update
    // one sample per off-time, plus one per skipped cycle, feeds both counters
    if (enter_hiccup) begin
      nxt_oc_cnt = '0; // RULE18
      nxt_clean_cnt = '0;
    end else if (off_sample) begin
      if (i_ls_over_limit) begin
        nxt_oc_cnt = oc_cnt_ff + ONE_C; // RULE9 RULE16
        nxt_clean_cnt = '0;
      end else if (clean_cnt_ff + ONE_C >= CLR_RUN) begin
        nxt_oc_cnt = '0; // RULE10
        nxt_clean_cnt = '0;
      end else begin
        nxt_clean_cnt = clean_cnt_ff + ONE_C;
      end
    end
    // any gap in the indication restarts the filter
    if (!enter_hiccup && mode_ff == BFP_RUN && i_ext_ss_done &&
      i_output_undervoltage_guard) begin
      nxt_uv_tmr = uv_tmr_ff + ONE_T; // RULE13 RULE14
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      oc_cnt_ff <= '0;
      clean_cnt_ff <= '0;
      uv_tmr_ff <= '0;
    end else begin
      oc_cnt_ff <= nxt_oc_cnt;
      clean_cnt_ff <= nxt_clean_cnt;
      uv_tmr_ff <= nxt_uv_tmr;
    end
  end

  assign o_hs_gate = hs_gate_ff;
  assign o_ls_gate = ls_gate_ff;
  assign o_current_limit = climit_ff;
  assign o_hiccup = hiccup_ff;
  assign o_internal_ss = iss_ff;
  assign o_hs_blank = blank_ff;

endmodule : bfp_sequencer
`default_nettype wire

/* File: sim/bfp_sequencer_props.sv */
// port assertions for the fault-protection sequencer
`timescale 1ns/10ps
`default_nettype none
module bfp_sequencer_props
  import bfp_pkg::*;
#(
  parameter int unsigned P_COOL_CYC = COOL_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cycle_start,
  input wire logic i_pwm_end,
  input wire logic i_ls_over_limit,
  input wire logic i_hs_over_limit,
  input wire logic i_output_undervoltage_guard,
  input wire logic i_ext_ss_done,
  input wire logic o_hs_gate,
  input wire logic o_ls_gate,
  input wire logic o_current_limit,
  input wire logic o_hiccup,
  input wire logic o_internal_ss,
  input wire logic o_hs_blank
);
  localparam int CLO = P_COOL_CYC - 1;
  localparam int CHI = P_COOL_CYC + 1;
  logic [11:0] uv_cnt_ff;
  logic [11:0] nxt_uv_cnt;
  logic [7:0] off_run_ff;
  logic [7:0] nxt_off_run;
  // run of armed undervoltage samples
  always_comb begin
    nxt_uv_cnt = uv_cnt_ff + 12'h001;
    if (!i_nrst || o_hiccup || o_internal_ss || !i_ext_ss_done ||
        !i_output_undervoltage_guard) begin
      nxt_uv_cnt = 12'h000;
    end
  end
  // run of low-side on cycles, saturating
  always_comb begin
    nxt_off_run = 8'h00;
    if (o_ls_gate) begin
      nxt_off_run = (off_run_ff == 8'hFF) ? off_run_ff : off_run_ff + 8'h01;
    end
  end
  always_ff @(posedge i_clk) begin
    uv_cnt_ff <= nxt_uv_cnt;
    off_run_ff <= nxt_off_run;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  gates_off_a: assert property (
    o_hiccup |-> !o_hs_gate && !o_ls_gate) else $error("gate on in hiccup");
  cool_len_a: assert property (
    $rose(o_hiccup) |-> ##[CLO:CHI] $rose(o_internal_ss))
    else $error("cool-down length wrong");
  pwm_off_a: assert property (
    o_hs_gate && i_pwm_end |=> !o_hs_gate) else $error("pulse not ended");
  hs_trip_a: assert property (
    o_hs_gate && !o_hs_blank && i_hs_over_limit |=> o_hiccup)
    else $error("high-side trip missed");
  blank_hold_a: assert property (
    o_hs_blank && i_hs_over_limit && !i_ls_over_limit &&
    !i_output_undervoltage_guard |=> !$rose(o_hiccup))
    else $error("trip during blanking");
  uv_gate_a: assert property (
    (o_internal_ss || !i_ext_ss_done) && !i_hs_over_limit &&
    !i_ls_over_limit |=> !$rose(o_hiccup)) else $error("early uv trip");
  uv_filter_a: assert property (
    uv_cnt_ff <= 12'h6DA) else $error("uv filter too slow");
  ls_sample_a: assert property (
    $fell(o_hs_gate) && o_ls_gate ##13 i_ls_over_limit |->
    ##[1:2] (o_current_limit || o_hiccup)) else $error("limit not taken");
  min_off_a: assert property (
    $rose(o_hs_gate) && $past(o_ls_gate) |-> off_run_ff >= MIN_OFF_CYC)
    else $error("off-time too short");
endmodule : bfp_sequencer_props
`default_nettype wire

/* File: sim/bfp_power_stage_model.sv */
// power-stage stand-in: switching clock, pwm and fault comparators
`timescale 1ns/10ps
`default_nettype none
module bfp_power_stage_model #(
  parameter int PER = 120,
  parameter int DUTY = 60
) (
  input wire logic i_clk,
  input wire logic i_hs_gate,
  input wire logic i_ls_gate,
  input wire logic i_ls_fault,
  input wire logic i_hs_short,
  output logic o_cycle_start,
  output logic o_pwm_end,
  output logic o_ls_over_limit,
  output logic o_hs_over_limit
);
  int cnt = 0;
  int on = 0;
  // comparators report only while their switch conducts
  always @(posedge i_clk) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    on <= i_hs_gate ? on + 1 : 0;
    o_cycle_start <= (cnt == PER - 1);
    o_pwm_end <= i_hs_gate && on >= DUTY - 1;
    o_ls_over_limit <= i_ls_gate && i_ls_fault;
    o_hs_over_limit <= i_hs_gate && i_hs_short;
  end
endmodule : bfp_power_stage_model
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the fault-protection sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bfp_pkg::*;
  localparam int PER = 120;
  logic clk, nrst, cs, pe, lso, hso, uv, ssd, lsf, hss;
  logic hs, ls, cl, hic, iss, blk, p;
  int errors = 0, n_tests = 0, seen, n;
  bfp_sequencer #(.P_COOL_CYC(100), .P_ISS_CYC(2000)) u_bfp_sequencer (
    .i_clk(clk), .i_nrst(nrst), .i_cycle_start(cs), .i_pwm_end(pe),
    .i_ls_over_limit(lso), .i_hs_over_limit(hso),
    .i_output_undervoltage_guard(uv), .i_ext_ss_done(ssd),
    .o_hs_gate(hs), .o_ls_gate(ls), .o_current_limit(cl),
    .o_hiccup(hic), .o_internal_ss(iss), .o_hs_blank(blk));
  bfp_power_stage_model #(.PER(PER)) u_bfp_power_stage_model (
    .i_clk(clk), .i_hs_gate(hs), .i_ls_gate(ls), .i_ls_fault(lsf),
    .i_hs_short(hss), .o_cycle_start(cs), .o_pwm_end(pe),
    .o_ls_over_limit(lso), .o_hs_over_limit(hso));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      errors++;
      $display("BAD %s exp %0d got %0d", what, e, g);
    end
  endtask : chk
  // c cycles: n counts high-side pulses, seen counts hiccup cycles
  task automatic run(input int c);
    n = 0;
    p = hs;
    repeat (c) begin
      @(negedge clk);
      n += hs && !p;
      p = hs;
      seen += hic;
    end
  endtask : run
  task automatic to_hic(input int lim);
    n = 0;
    while (!hic && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : to_hic
  task automatic on_rise;
    while (hs) @(negedge clk);
    while (!hs) @(negedge clk);
  endtask : on_rise
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #300000;
    errors++;
    close_out();
  end
  initial begin
    {nrst, uv, lsf, hss, p} = '0;
    ssd = 1;
    seen = $urandom(34);
    repeat (4) @(negedge clk);
    chk("reset outs", 0, {hs, ls, cl, hic, iss, blk});
    nrst = 1;
    run(PER);
    run(10 * PER);
    chk("hs pulses", 10, n);
    seen = 0;
    repeat (3) begin
      uv = 1;
      run(100 + $urandom % 1600);
      uv = 0;
      run(20);
    end
    ssd = 0;
    uv = 1;
    run(2000);
    chk("uv filtered", 0, seen);
    uv = 0;
    ssd = 1;
    run(2);
    uv = 1;
    to_hic(2000);
    uv = 0;
    chk("uv delay", 1, n >= UV_FILTER_CYC && n <= UV_FILTER_CYC + 4);
    run(103);
    chk("cool done", 1, {hic, iss} == 2'b01);
    uv = 1;
    seen = 0;
    run(1900);
    uv = 0;
    chk("uv in ss", 0, seen);
    run(300);
    on_rise();
    chk("blank on", 1, blk);
    hss = 1;
    to_hic(200);
    hss = 0;
    chk("hs blank", 1, n >= 48 && n <= 53);
    run(2300);
    on_rise();
    lsf = 1;
    run(3 * PER);
    chk("limit mode", 1, cl);
    chk("skipped pulses", 0, n);
    chk("low held on", 1, ls);
    to_hic(2500);
    chk("ls count", 1, hic && n + 3 * PER > 13 * PER);
    lsf = 0;
    run(2300);
    seen = 0;
    repeat (3) begin
      lsf = 1;
      run((5 + $urandom % 4) * PER);
      lsf = 0;
      run(5);
      chk("resume high", 1, n);
      run(40 * PER);
    end
    chk("count cleared", 0, seen);
    close_out();
  end
endmodule : testbench
bind bfp_sequencer bfp_sequencer_props #(.P_COOL_CYC(P_COOL_CYC))
  u_bfp_sequencer_props (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cycle_start(i_cycle_start),
    .i_pwm_end(i_pwm_end),
    .i_ls_over_limit(i_ls_over_limit),
    .i_hs_over_limit(i_hs_over_limit),
    .i_output_undervoltage_guard(i_output_undervoltage_guard),
    .i_ext_ss_done(i_ext_ss_done),
    .o_hs_gate(o_hs_gate),
    .o_ls_gate(o_ls_gate),
    .o_current_limit(o_current_limit),
    .o_hiccup(o_hiccup),
    .o_internal_ss(o_internal_ss),
    .o_hs_blank(o_hs_blank));
`default_nettype wire
